/* File: include/isp_pkg.sv */
/*
  Shared constants and types for the I2C slave command port.
  Assumes a system clock domain and a separate SCK link domain.
*/
package isp_pkg;
  // Address layout
  localparam int ADDR_W = 7;
  localparam logic [1:0] ADDR_FIXED_TOP = 2'h3;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] MAX_BYTES = 4'h8;

  // Command byte codes
  localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h81;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'hFC;
  localparam logic [7:0] CMD_READ_PROM_PARAMS = 8'h82;
  localparam logic [7:0] CMD_GO_SAFE_POSITION = 8'h84;
  localparam logic [7:0] CMD_IMMEDIATE_HALT = 8'h85;
  localparam logic [7:0] CMD_ZERO_ACTUAL_POSITION = 8'h86;
  localparam logic [7:0] CMD_RELOAD_PROM_DEFAULTS = 8'h87;
  localparam logic [7:0] CMD_TWO_POINT_MOVE = 8'h88;
  localparam logic [7:0] CMD_WRITE_MOTOR_PARAMS = 8'h89;
  localparam logic [7:0] CMD_PROGRAM_PROM = 8'h90;
  localparam logic [7:0] CMD_WRITE_TARGET_POSITION = 8'h8B;
  localparam logic [7:0] CMD_WRITE_STALL_PARAMS = 8'h96;
  localparam logic [7:0] CMD_RAMPED_HALT = 8'h8F;
  localparam logic [7:0] CMD_RUN_VELOCITY = 8'h97;
  localparam logic [7:0] CMD_BACK_EMF_OBSERVE = 8'h9F;

  // Decoded command, binary-encoded index
  typedef enum logic [3:0] {
    ISP_CMD_NONE,
    ISP_CMD_READ_STATUS_ONE,
    ISP_CMD_READ_STATUS_TWO,
    ISP_CMD_READ_PROM_PARAMS,
    ISP_CMD_GO_SAFE_POSITION,
    ISP_CMD_IMMEDIATE_HALT,
    ISP_CMD_ZERO_ACTUAL_POSITION,
    ISP_CMD_RELOAD_PROM_DEFAULTS,
    ISP_CMD_TWO_POINT_MOVE,
    ISP_CMD_WRITE_MOTOR_PARAMS,
    ISP_CMD_PROGRAM_PROM,
    ISP_CMD_WRITE_TARGET_POSITION,
    ISP_CMD_WRITE_STALL_PARAMS,
    ISP_CMD_RAMPED_HALT,
    ISP_CMD_RUN_VELOCITY,
    ISP_CMD_BACK_EMF_OBSERVE
  } isp_cmd_type;

  // Received byte handed to the system domain
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] index;
    logic general_call;
  } isp_rx_type;
endpackage

/* File: logic/isp_slave.sv */
/*
  I2C slave command port: SCK-domain bit engine plus system-domain
  command decoder and read-data handshake.
  Assumes an open-drain bus resolved outside, SCK as the link clock,
  and a system clock far faster than SCK.
*/
`timescale 1ns/1ps
// What this block does
// - Transmitter releases SDA during the ninth, acknowledge clock pulse.
// - Receiver drives SDA low through the whole high time of acknowledge.
// - Address not selecting this device is not acknowledged; SDA left high.
// - Receiver unable to accept more bytes not-acknowledges the next byte.
// - As transmitter, release SDA after a not-acknowledged byte.
// - First byte is 7-bit address plus direction; zero write, one read.
// - Incoming SDA sampled on each rising SCK edge.
// - Each correctly received write data byte is acknowledged.
// - Write payload is up to seven data bytes after the command byte, for any command.
// - Internal address byte of a write is kept for the following read.
// - Any start resets bus logic and expects an address byte.
// - Seven address bits compared; match selects receiver or transmitter.
// - Address is fixed 11, four PROM bits, then the strap pin bit.
// - General-call all-zero address is acknowledged; next byte is action.
// - Decode 0x81, 0xFC, 0x82 as the three status reads.
// - Decode 0x84, 0x85, 0x8F as safe position, halt, ramped halt.
// - 0x86 zeroes actual position; 0x87 reloads PROM defaults.
// - Decode 0x8B, 0x88, 0x97 as target, two-point move, run.
// - Decode 0x89, 0x96, 0x90 as motor, stall, PROM programming.
// - At most eight bytes per write transfer, most significant bit first.
// - Hold SCK low while not ready, release once ready.
// - Start is SDA fall with SCK high; stop is SDA rise; repeated same.
module isp_slave
  import isp_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_sck, // Bus clock, link domain
  input wire logic i_sda, // Bus data level
  input wire logic [3:0] i_prom_addr, // PROM address bits
  input wire logic i_strap_address_pin, // Strap address bit
  input wire logic [7:0] i_tx_data, // Read data for the master
  input wire logic i_tx_valid, // Read data available
  output logic o_sda_oe, // Pull SDA low when high
  output logic o_sda_o, // SDA drive value, always 0
  output logic o_sck_oe, // Stretch SCK low when high
  output logic o_sck_o, // SCK drive value, always 0
  output logic o_tx_taken, // Pulse: read byte consumed
  output logic [7:0] o_internal_addr, // Stored internal address
  output logic o_read_start, // Pulse: read transfer began
  output isp_cmd_type o_cmd, // Decoded command
  output logic o_cmd_valid, // Pulse: command decoded
  output logic o_general_call, // Command came via general call
  output logic [7:0] o_data_byte, // Payload byte
  output logic [3:0] o_data_index, // Payload byte position
  output logic o_data_valid, // Pulse: payload byte
  output logic o_stop_seen // Pulse: stop condition
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_IGNORE
  } isp_state_type;

  // Command decode shared by both code paths
  function automatic isp_cmd_type decode(input logic [7:0] b);
    isp_cmd_type c;
    c = ISP_CMD_NONE;
    unique case (b)
      CMD_READ_STATUS_ONE: c = ISP_CMD_READ_STATUS_ONE;
      CMD_READ_STATUS_TWO: c = ISP_CMD_READ_STATUS_TWO;
      CMD_READ_PROM_PARAMS: c = ISP_CMD_READ_PROM_PARAMS;
      CMD_GO_SAFE_POSITION: c = ISP_CMD_GO_SAFE_POSITION;
      CMD_IMMEDIATE_HALT: c = ISP_CMD_IMMEDIATE_HALT;
      CMD_RAMPED_HALT: c = ISP_CMD_RAMPED_HALT;
      CMD_ZERO_ACTUAL_POSITION: c = ISP_CMD_ZERO_ACTUAL_POSITION;
      CMD_RELOAD_PROM_DEFAULTS: c = ISP_CMD_RELOAD_PROM_DEFAULTS;
      CMD_WRITE_TARGET_POSITION: c = ISP_CMD_WRITE_TARGET_POSITION;
      CMD_TWO_POINT_MOVE: c = ISP_CMD_TWO_POINT_MOVE;
      CMD_RUN_VELOCITY: c = ISP_CMD_RUN_VELOCITY;
      CMD_WRITE_MOTOR_PARAMS: c = ISP_CMD_WRITE_MOTOR_PARAMS;
      CMD_WRITE_STALL_PARAMS: c = ISP_CMD_WRITE_STALL_PARAMS;
      CMD_PROGRAM_PROM: c = ISP_CMD_PROGRAM_PROM;
      CMD_BACK_EMF_OBSERVE: c = ISP_CMD_BACK_EMF_OBSERVE;
      default: c = ISP_CMD_NONE;
    endcase
    return c;
  endfunction

  // ---------------- SCK domain ----------------
  // Start/stop detect: SDA edges while SCK high, clocked by SDA itself
  logic start_tog_q, stop_tog_q;
  always_ff @(negedge i_sda or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_tog_q <= 1'b0;
    end else if (i_sck) begin
      start_tog_q <= ~start_tog_q;
    end
  end
  always_ff @(posedge i_sda or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_tog_q <= 1'b0;
    end else if (i_sck) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // Start seen in SCK domain: compare toggle with last handled copy
  logic start_ack_q, start_ack_d;
  logic start_pend;
  assign start_pend = start_tog_q ^ start_ack_q;

  isp_state_type st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic rw_q, rw_d, gc_q, gc_d, ack_q, ack_d, first_q, first_d;
  logic rx_tog_q, rx_tog_d, rd_tog_q, rd_tog_d;
  isp_rx_type rx_q, rx_d;
  logic [7:0] txb_q, txb_d;
  logic tx_tog_q, tx_tog_d;
  logic [6:0] my_addr;
  assign my_addr = {ADDR_FIXED_TOP, i_prom_addr, i_strap_address_pin};

  // Next-state logic on rising SCK
  always_comb begin
    st_d = st_q;
    bit_d = bit_q + 3'h1;
    sh_d = {sh_q[6:0], i_sda};
    cnt_d = cnt_q;
    rw_d = rw_q;
    gc_d = gc_q;
    ack_d = ack_q;
    first_d = first_q;
    rx_tog_d = rx_tog_q;
    rd_tog_d = rd_tog_q;
    rx_d = rx_q;
    txb_d = txb_q;
    tx_tog_d = tx_tog_q;
    start_ack_d = start_tog_q;
    if (start_pend) begin
      // First rising edge after start is address bit 7
      st_d = ST_ADDR;
      bit_d = 3'h1;
      sh_d = {7'h00, i_sda};
      cnt_d = 4'h0;
      first_d = 1'b1;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_IGNORE: begin
          bit_d = bit_q;
        end
        ST_ADDR, ST_RX: begin
          if (bit_q == BIT_LAST) begin
            st_d = ST_ACK;
            ack_d = 1'b1;
            if (st_q == ST_ADDR) begin
              rw_d = i_sda;
              gc_d = (sh_q[6:0] == GENERAL_CALL_ADDR) && !i_sda;
              ack_d = (sh_q[6:0] == my_addr[6:0]) || gc_d;
              if (i_sda && ack_d) begin
                rd_tog_d = ~rd_tog_q;
              end
            end else begin
              ack_d = (cnt_q < MAX_BYTES);
              if (ack_d) begin
                rx_d.data = {sh_q[6:0], i_sda};
                rx_d.index = cnt_q;
                rx_d.general_call = gc_q;
                rx_tog_d = ~rx_tog_q;
                cnt_d = cnt_q + 4'h1;
              end
            end
          end
        end
        ST_ACK: begin
          bit_d = 3'h0;
          if (!ack_q) begin
            st_d = ST_IGNORE;
          end else if (rw_q && first_q) begin
            st_d = ST_TX;
            txb_d = i_tx_data;
            tx_tog_d = ~tx_tog_q;
          end else begin
            st_d = ST_RX;
          end
          first_d = 1'b0;
        end
        ST_TX: begin
          if (bit_q == BIT_LAST) begin
            st_d = ST_TXACK;
          end
        end
        ST_TXACK: begin
          bit_d = 3'h0;
          if (i_sda) begin
            st_d = ST_IGNORE;
          end else begin
            st_d = ST_TX;
            txb_d = i_tx_data;
            tx_tog_d = ~tx_tog_q;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      ack_q <= 1'b0;
      first_q <= 1'b0;
      rx_tog_q <= 1'b0;
      rd_tog_q <= 1'b0;
      rx_q <= '0;
      txb_q <= 8'h00;
      tx_tog_q <= 1'b0;
      start_ack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      gc_q <= gc_d;
      ack_q <= ack_d;
      first_q <= first_d;
      rx_tog_q <= rx_tog_d;
      rd_tog_q <= rd_tog_d;
      rx_q <= rx_d;
      txb_q <= txb_d;
      tx_tog_q <= tx_tog_d;
      start_ack_q <= start_ack_d;
    end
  end

  // SDA drive and stretch request, updated on falling SCK so data is stable while high
  logic sda_oe_q, sda_oe_d, sck_oe_q, sck_oe_d, stretch_q, stretch_d;
  always_comb begin
    sda_oe_d = 1'b0;
    sck_oe_d = 1'b0;
    if (!start_pend) begin
      unique case (st_q)
        ST_ACK: sda_oe_d = ack_q;
        ST_TX: sda_oe_d = !txb_q[BIT_LAST - bit_q];
        default: sda_oe_d = 1'b0;
      endcase
      // Ask for a stretch at read byte starts; the system side releases it
      if ((st_q == ST_ACK && ack_q && rw_q && first_q) || (st_q == ST_TXACK)) begin
        sck_oe_d = 1'b1;
      end
    end
  end

  // Register SDA drive and stretch request on falling SCK
  always_ff @(negedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_oe_q <= 1'b0;
      sck_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= sda_oe_d;
      sck_oe_q <= sck_oe_d;
    end
  end
  assign o_sda_oe = sda_oe_q;
  assign o_sck_oe = stretch_q; // System flop, so a stretch can end with SCK held
  assign o_sda_o = 1'b0;
  assign o_sck_o = 1'b0;

  // ---------------- System domain ----------------
  // Three-stage synchronisers for toggles crossing from the link
  logic [2:0] rx_s_q, rd_s_q, tx_s_q, sp_s_q, req_s_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_s_q <= 3'h0;
      rd_s_q <= 3'h0;
      tx_s_q <= 3'h0;
      req_s_q <= 3'h0;
      sp_s_q <= 3'h0;
    end else begin
      rx_s_q <= {rx_s_q[1:0], rx_tog_q};
      rd_s_q <= {rd_s_q[1:0], rd_tog_q};
      tx_s_q <= {tx_s_q[1:0], tx_tog_q};
      req_s_q <= {req_s_q[1:0], sck_oe_q};
      sp_s_q <= {sp_s_q[1:0], stop_tog_q};
    end
  end

  logic rx_ev, rd_ev, tx_ev, sp_ev;
  logic rx_l_q, rd_l_q, tx_l_q, sp_l_q;
  // Toggle change counts once stages two and three agree
  assign rx_ev = (rx_s_q[1] == rx_s_q[2]) && (rx_s_q[2] != rx_l_q);
  assign rd_ev = (rd_s_q[1] == rd_s_q[2]) && (rd_s_q[2] != rd_l_q);
  assign tx_ev = (tx_s_q[1] == tx_s_q[2]) && (tx_s_q[2] != tx_l_q);
  assign sp_ev = (sp_s_q[1] == sp_s_q[2]) && (sp_s_q[2] != sp_l_q);

  isp_cmd_type cmd_q, cmd_d;
  logic cmd_v_q, cmd_v_d, gcall_q, gcall_d;
  logic [7:0] iaddr_q, iaddr_d, db_q, db_d;
  logic [3:0] di_q, di_d;
  logic dv_q, dv_d, rs_q, rs_d, tk_q, tk_d, sp_q, sp_d;

  // Hand-off of received bytes; rx_q is stable once its toggle settles
  always_comb begin
    cmd_d = cmd_q;
    cmd_v_d = 1'b0;
    gcall_d = gcall_q;
    iaddr_d = iaddr_q;
    db_d = db_q;
    di_d = di_q;
    dv_d = 1'b0;
    rs_d = rd_ev;
    tk_d = tx_ev;
    sp_d = sp_ev;
    stretch_d = req_s_q[1] && req_s_q[2] && !i_tx_valid;
    if (rx_ev) begin
      if (rx_q.index == 4'h0) begin
        cmd_d = decode(rx_q.data);
        cmd_v_d = (decode(rx_q.data) != ISP_CMD_NONE);
        gcall_d = rx_q.general_call;
        iaddr_d = rx_q.data;
      end else begin
        db_d = rx_q.data;
        di_d = rx_q.index;
        dv_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_l_q <= 1'b0;
      rd_l_q <= 1'b0;
      tx_l_q <= 1'b0;
      sp_l_q <= 1'b0;
      cmd_q <= ISP_CMD_NONE;
      cmd_v_q <= 1'b0;
      gcall_q <= 1'b0;
      iaddr_q <= 8'h00;
      db_q <= 8'h00;
      di_q <= 4'h0;
      dv_q <= 1'b0;
      rs_q <= 1'b0;
      tk_q <= 1'b0;
      sp_q <= 1'b0;
      stretch_q <= 1'b0;
    end else begin
      rx_l_q <= rx_s_q[2];
      rd_l_q <= rd_s_q[2];
      tx_l_q <= tx_s_q[2];
      sp_l_q <= sp_s_q[2];
      cmd_q <= cmd_d;
      cmd_v_q <= cmd_v_d;
      gcall_q <= gcall_d;
      iaddr_q <= iaddr_d;
      db_q <= db_d;
      di_q <= di_d;
      dv_q <= dv_d;
      rs_q <= rs_d;
      tk_q <= tk_d;
      sp_q <= sp_d;
      stretch_q <= stretch_d;
    end
  end

  assign o_cmd = cmd_q;
  assign o_cmd_valid = cmd_v_q;
  assign o_general_call = gcall_q;
  assign o_internal_addr = iaddr_q;
  assign o_data_byte = db_q;
  assign o_data_index = di_q;
  assign o_data_valid = dv_q;
  assign o_read_start = rs_q;
  assign o_tx_taken = tk_q;
  assign o_stop_seen = sp_q;

endmodule // isp_slave

/* File: verification/isp_slave_assertions.sv */
/*
  Checker for the I2C slave command port, bound to its top ports.
  Assumes one system clock domain and an active-low async reset.
*/
`timescale 1ns/1ps
module isp_slave_assertions
  import isp_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_sck, // Bus clock level
  input wire logic i_tx_valid, // Read data ready
  input wire logic o_sda_oe, // SDA pull-down
  input wire logic o_sda_o, // SDA drive value
  input wire logic o_sck_oe, // SCK stretch
  input wire logic o_sck_o, // SCK drive value
  input wire logic o_tx_taken, // Read byte consumed
  input wire logic o_read_start, // Read began
  input wire isp_cmd_type o_cmd, // Decoded command
  input wire logic o_cmd_valid, // Command pulse
  input wire logic o_general_call, // Via general call
  input wire logic [3:0] o_data_index, // Payload position
  input wire logic o_data_valid, // Payload pulse
  input wire logic o_stop_seen // Stop pulse
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Bus pins and decoder outputs
  a_pins_open_drain: assert property (o_sda_o == 1'b0 && o_sck_o == 1'b0)
    else $error("open-drain drive value not zero");
  a_sda_steady: assert property (i_sck && $past(i_sck) |-> $stable(o_sda_oe))
    else $error("SDA drive changed while SCK high");
  a_sda_launch: assert property (!$stable(o_sda_oe) |-> !i_sck)
    else $error("SDA drive changed outside SCK low");
  a_cmd_known: assert property (o_cmd_valid |-> o_cmd != ISP_CMD_NONE)
    else $error("command pulse with no command");
  a_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("command pulse longer than one cycle");
  a_cmd_not_data: assert property (o_cmd_valid |-> !o_data_valid)
    else $error("command byte given as payload");
  a_data_index: assert property (o_data_valid |-> o_data_index inside {[4'h1:4'h7]})
    else $error("payload index out of range");
  a_stop_pulse: assert property (o_stop_seen |=> !o_stop_seen [*8])
    else $error("stop pulse repeated");
  a_stretch_end: assert property (o_sck_oe && i_tx_valid |-> ##[1:1000] !o_sck_oe)
    else $error("SCK held after data became ready");
  a_taken_valid: assert property (o_tx_taken |-> i_tx_valid)
    else $error("read byte taken while not ready");
  // Main scenarios
  c_gcall: cover property (o_cmd_valid && o_general_call);
  c_last_byte: cover property (o_data_valid && o_data_index == 4'h7);
  c_read: cover property (o_read_start);
  c_taken: cover property (o_tx_taken);
endmodule // isp_slave_assertions

/* File: verification/isp_master.sv */
/*
  Behavioural I2C bus master driving open-drain enables.
  Assumes a pull-up resolution outside; bit period 125 ns.
*/
`timescale 1ns/1ps
module isp_master (
  input wire logic i_sck, // Resolved SCK
  input wire logic i_sda, // Resolved SDA
  output logic o_sck_oe, // Pull SCK low
  output logic o_sda_oe // Pull SDA low
);
  localparam realtime Q = 31.25; // Quarter bit
  // SCK held low until the first frame
  initial begin
    o_sck_oe = 1'b1;
    o_sda_oe = 1'b0;
  end
  // One clock pulse, waiting out any stretch
  task automatic pulse(output logic b);
    #Q o_sck_oe = 1'b0;
    wait (i_sck);
    b = i_sda; // Sampled on rising SCK
    #(2*Q) o_sck_oe = 1'b1;
    #Q;
  endtask
  task automatic wbit(input logic b);
    logic x;
    o_sda_oe = !b;
    pulse(x);
  endtask
  // SDA falls while SCK high
  task automatic start();
    o_sda_oe = 1'b0;
    #Q o_sck_oe = 1'b0;
    wait (i_sck);
    #Q o_sda_oe = 1'b1;
    #Q o_sck_oe = 1'b1;
    #Q;
  endtask
  // SDA rises while SCK high, never right after start
  task automatic stop();
    o_sda_oe = 1'b1;
    #Q o_sck_oe = 1'b0;
    wait (i_sck);
    #Q o_sda_oe = 1'b0;
    #(2*Q);
  endtask
  // MSB first, SDA released for the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    o_sda_oe = 1'b0;
    pulse(nack);
  endtask
  // Acknowledge every byte but the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    o_sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    wbit(last);
  endtask
endmodule // isp_master

/* File: verification/isp_slave_tb.sv */
/*
  Self-checking bench for the I2C slave command port.
  Assumes the master model beside it and a pull-up on both lines.
*/
`timescale 1ns/1ps
module isp_slave_tb
  import isp_pkg::*;
;
  localparam logic [7:0] CODES [16] = '{CMD_READ_STATUS_ONE, CMD_READ_STATUS_TWO,
    CMD_READ_PROM_PARAMS, CMD_GO_SAFE_POSITION, CMD_IMMEDIATE_HALT,
    CMD_ZERO_ACTUAL_POSITION, CMD_RELOAD_PROM_DEFAULTS, CMD_TWO_POINT_MOVE,
    CMD_WRITE_MOTOR_PARAMS, CMD_PROGRAM_PROM, CMD_WRITE_TARGET_POSITION,
    CMD_WRITE_STALL_PARAMS, CMD_RAMPED_HALT, CMD_RUN_VELOCITY, CMD_BACK_EMF_OBSERVE, 8'h80};
  localparam logic [6:0] MISM [3] = '{7'h01, 7'h10, 7'h40};
  logic i_sys_clk, i_rst_n, i_strap_address_pin, i_tx_valid, m_sck, m_sda;
  logic [3:0] i_prom_addr, o_data_index;
  logic [7:0] i_tx_data, o_internal_addr, o_data_byte, d;
  logic o_sda_oe, o_sda_o, o_sck_oe, o_sck_o, o_tx_taken, o_read_start;
  logic o_cmd_valid, o_general_call, o_data_valid, o_stop_seen;
  isp_cmd_type o_cmd;
  int n_errors, comparisons, ns, se, nr, k, nst;
  isp_cmd_type cq[$];
  logic [11:0] dq[$], ex[$];
  logic [7:0] txq[$];
  wire sck = !(m_sck | o_sck_oe);
  wire sda = !(m_sda | o_sda_oe);
  isp_slave uut (.i_sys_clk, .i_rst_n, .i_sck(sck), .i_sda(sda), .i_prom_addr,
    .i_strap_address_pin, .i_tx_data, .i_tx_valid, .o_sda_oe, .o_sda_o, .o_sck_oe,
    .o_sck_o, .o_tx_taken, .o_internal_addr, .o_read_start, .o_cmd, .o_cmd_valid,
    .o_general_call, .o_data_byte, .o_data_index, .o_data_valid, .o_stop_seen);
  isp_master m (.i_sck(sck), .i_sda(sda), .o_sck_oe(m_sck), .o_sda_oe(m_sda));
  // System clock, 5 ns
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // Collect system-side pulses, away from the launching edge
  always @(negedge i_sys_clk) begin
    if (o_sck_oe === 1'b1) nst++;
    if (o_cmd_valid === 1'b1) cq.push_back(o_cmd);
    if (o_data_valid === 1'b1) dq.push_back({o_data_index, o_data_byte});
    if (o_stop_seen === 1'b1) ns++;
    if (o_read_start === 1'b1) nr++;
  end
  // Present the next read byte once one is taken
  always @(negedge i_sys_clk) if (o_tx_taken === 1'b1) begin
    k++;
    i_tx_data <= txq[k % 4];
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic logic [6:0] own();
    return {ADDR_FIXED_TOP, i_prom_addr, i_strap_address_pin};
  endfunction
  task automatic wb(logic [7:0] v, logic e);
    logic n;
    m.wbyte(v, n);
    chk("ack", e, n);
  endtask
  task automatic go(logic [6:0] ad, logic rw, logic e);
    m.start();
    wb({ad, rw}, e);
  endtask
  task automatic endf(int n, isp_cmd_type c);
    m.stop();
    se++;
    repeat (40) @(posedge i_sys_clk);
    chk("stops", se, ns);
    chk("cmds", n, cq.size());
    if (n > 0) chk("cmd", c, cq[0]);
    cq.delete();
  endtask
  task automatic finish_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    {i_rst_n, i_prom_addr, i_strap_address_pin, i_tx_data, i_tx_valid} = '0;
    k = $urandom(32'h7B4B);
    k = 0;
    repeat (4) txq.push_back(8'($urandom));
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(negedge i_sys_clk) {i_prom_addr, i_strap_address_pin} = 5'($urandom);
      go(own(), 1'b0, 1'b0);
      wb(CODES[i], 1'b0);
      endf(int'(i < 15), isp_cmd_type'(i + 1));
      chk("iaddr", CODES[i], o_internal_addr);
    end
    chk("cmd", ISP_CMD_NONE, o_cmd);
    go(own(), 1'b0, 1'b0);
    wb(CMD_WRITE_MOTOR_PARAMS, 1'b0);
    for (int i = 1; i < 8; i++) begin
      d = 8'($urandom);
      ex.push_back({4'(i), d});
      wb(d, 1'b0);
    end
    wb(8'hA5, 1'b1);
    endf(1, ISP_CMD_WRITE_MOTOR_PARAMS);
    chk("nbytes", 7, dq.size());
    foreach (ex[j]) chk("byte", ex[j], dq[j]);
    foreach (MISM[j]) begin
      go(own() ^ MISM[j], 1'b0, 1'b1);
      wb(CMD_IMMEDIATE_HALT, 1'b1);
      endf(0, ISP_CMD_NONE);
    end
    go(GENERAL_CALL_ADDR, 1'b0, 1'b0);
    wb(CMD_IMMEDIATE_HALT, 1'b0);
    endf(1, ISP_CMD_IMMEDIATE_HALT);
    chk("gcall", 1, o_general_call);
    m.start();
    for (int i = 0; i < 4; i++) m.wbit(i[0]);
    go(own(), 1'b0, 1'b0);
    wb(CMD_ZERO_ACTUAL_POSITION, 1'b0);
    endf(1, ISP_CMD_ZERO_ACTUAL_POSITION);
    chk("gcall", 0, o_general_call);
    @(negedge i_sys_clk) i_tx_data = txq[0];
    nst = 0;
    // Read data arrives late, so the first read byte start is stretched
    fork
      begin
        #6000;
        @(negedge i_sys_clk) i_tx_valid = 1'b1;
      end
    join_none
    go(own(), 1'b0, 1'b0);
    wb(CMD_READ_STATUS_TWO, 1'b0);
    go(own(), 1'b1, 1'b0);
    chk("stretch", 1, nst > 0);
    for (int i = 0; i < 3; i++) begin
      m.rbyte(i == 2, d);
      chk("rdata", txq[i], d);
    end
    chk("release", 1, sda);
    endf(1, ISP_CMD_READ_STATUS_TWO);
    chk("reads", 1, nr);
    chk("taken", 3, k);
    chk("iaddr", CMD_READ_STATUS_TWO, o_internal_addr);
    finish_test();
  end
endmodule // isp_slave_tb
bind isp_slave isp_slave_assertions chk_i (.i_sys_clk, .i_rst_n, .i_sck, .i_tx_valid,
  .o_sda_oe, .o_sda_o, .o_sck_oe, .o_sck_o, .o_tx_taken, .o_read_start, .o_cmd,
  .o_cmd_valid, .o_general_call, .o_data_index, .o_data_valid, .o_stop_seen);
